/* ouvfr_pkg.sv */
package ouvfr_pkg;
  // channel count and byte layout of the response configuration
  localparam int OUVFR_NCH = 2;
  localparam int OUVFR_MODE_HI = 7;
  localparam int OUVFR_MODE_LO = 6;
  localparam int OUVFR_RETRY_HI = 5;
  localparam int OUVFR_RETRY_LO = 3;
  localparam int OUVFR_DLY_HI = 2;
  localparam int OUVFR_DLY_LO = 0;
  localparam logic [7:0] OUVFR_CFG_RESET = 8'hB8;
  // response modes and retry code
  localparam logic [1:0] OUVFR_MODE_IGNORE = 2'h0;
  localparam logic [1:0] OUVFR_MODE_DEGLITCH = 2'h1;
  localparam logic [1:0] OUVFR_MODE_SHUTDOWN = 2'h2;
  localparam logic [1:0] OUVFR_MODE_BAD = 2'h3;
  localparam logic [2:0] OUVFR_RETRY_ALWAYS = 3'h7;
  // timing: 10 us delay unit at a 40 ns clock
  localparam int OUVFR_CLK_NS = 40;
  localparam int OUVFR_DLY_UNIT_NS = 10000;
  localparam int OUVFR_UNIT_CYC = OUVFR_DLY_UNIT_NS / OUVFR_CLK_NS;
  localparam logic [15:0] OUVFR_RETRY_RESET = 16'h0064;
  // channel state, gray coded
  typedef enum logic [1:0] {
    OUVFR_ST_RUN = 2'b00,
    OUVFR_ST_DELAY = 2'b01,
    OUVFR_ST_OFF = 2'b11,
    OUVFR_ST_WAIT = 2'b10
  } ouvfr_state_e;
endpackage : ouvfr_pkg

/* ouvfr_tick.sv */
`timescale 1ns/1ps
// one-cycle pulse every 10 us
module ouvfr_tick
  import ouvfr_pkg::*;
#(
  parameter int UNIT_CYC = OUVFR_UNIT_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // unit pulse
  output logic tick
);
  logic [15:0] cnt_q;
  wire wrap = (cnt_q == 16'(UNIT_CYC - 1));

  // free-running divider
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_q <= 16'h0000;
      tick <= 1'b0;
    end else begin
      cnt_q <= wrap ? 16'h0000 : cnt_q + 16'h0001;
      tick <= wrap;
    end
  end
endmodule : ouvfr_tick

/* ouvfr_core.sv */
// Functional notes
// R1 - an undervoltage fault sets the channel's word-level output bit and undervoltage fault bit.
// R2 - every detected fault raises the alert output unless that fault's mask bit is set.
// R3 - undervoltage detection stays masked until timeout, delay, rise, level and no-overcurrent hold.
// R4 - undervoltage detection is masked while the channel is inactive.
// R5 - undervoltage detection is masked during ramp-up and ramp-down.
// R6 - response 00 keeps the output running and only records the fault.
// R7 - response 01 waits the programmed delay and applies the retry setting if the fault persists.
// R8 - response 10 disables the output at once and then applies the retry setting.
// R9 - writing response 11 is refused and raises a communication/memory/logic fault.
// R10 - retry codes 000 to 110 keep the output off until cleared or cycled off.
// R11 - retry code 111 restarts forever, spaced by the retry interval setting.
// R12 - bits 2:0 give the deglitch delay in 10 us units.
// R13 - status bits stay set until clear-faults, an off-then-on command, or reset.
// R14 - a turn-on timeout sets none-of-the-above, word output and timeout bits and alerts.
// R15 - a turn-on timeout limit of zero disables the timeout response.
// R16 - each channel holds its own configuration, counters, state and status, selected by page.
`timescale 1ns/1ps
module ouvfr_core
  import ouvfr_pkg::*;
#(
  parameter int NCH = OUVFR_NCH,
  parameter int UNIT_CYC = OUVFR_UNIT_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // command port: paged configuration access
  input wire logic [$clog2(NCH)-1:0] page,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic clear_faults,
  input wire logic [15:0] retry_interval_setting,
  input wire logic [NCH-1:0] ton_max_zero,
  // alert masks per channel
  input wire logic [NCH-1:0] uv_alert_mask,
  input wire logic [NCH-1:0] ton_alert_mask,
  // channel condition inputs
  input wire logic [NCH-1:0] channel_run_pin,
  input wire logic [NCH-1:0] operation_on,
  input wire logic [NCH-1:0] ton_max_reached,
  input wire logic [NCH-1:0] ton_delay_done,
  input wire logic [NCH-1:0] ton_rise_done,
  input wire logic [NCH-1:0] toff_fall_active,
  input wire logic [NCH-1:0] above_uv_limit,
  input wire logic [NCH-1:0] oc_present,
  input wire logic [NCH-1:0] uv_raw,
  input wire logic [NCH-1:0] ton_timeout,
  // status and control outputs
  output logic [NCH-1:0] output_enable,
  output logic [NCH-1:0] status_vout_uv,
  output logic [NCH-1:0] status_vout_ton,
  output logic [NCH-1:0] status_word_vout,
  output logic [NCH-1:0] status_byte_nota,
  output logic cml_fault,
  output logic alert_n
);
  logic tick;
  logic [NCH-1:0] alert_req;

  ouvfr_tick #(.UNIT_CYC(UNIT_CYC)) u_tick (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .tick(tick)
  );

  // refuse unsupported response code
  // R9 unsupported code
  wire bad_wr = cfg_wr && (cfg_wdata[OUVFR_MODE_HI:OUVFR_MODE_LO] == OUVFR_MODE_BAD);

  // R9 cml flag
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cml_fault <= 1'b0;
    end else if (bad_wr) begin
      cml_fault <= 1'b1;
    end else if (clear_faults) begin
      cml_fault <= 1'b0;
    end
  end

  // R2 alert output
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      alert_n <= 1'b1;
    end else begin
      alert_n <= ~(|alert_req | (bad_wr | cml_fault));
    end
  end

  logic [7:0] cfg_all [NCH];
  wire [7:0] cfg_sel = cfg_all[page];

  // registered read-back of the selected channel
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_rdata <= OUVFR_CFG_RESET;
    end else begin
      cfg_rdata <= cfg_sel;
    end
  end

  // R16 per-channel state
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic [7:0] cfg_q;
      ouvfr_state_e st_q;
      logic [15:0] cnt_q;
      logic on_q;
      logic uv_q, ton_q, armed_q;
      logic word_q;
      wire on_now = channel_run_pin[g] & operation_on[g];
      wire sel = (page == ($clog2(NCH))'(g));
      wire [1:0] mode = cfg_q[OUVFR_MODE_HI:OUVFR_MODE_LO];
      wire [2:0] retry = cfg_q[OUVFR_RETRY_HI:OUVFR_RETRY_LO];
      wire [2:0] dly = cfg_q[OUVFR_DLY_HI:OUVFR_DLY_LO];
      // R13 off-then-on clears
      wire cycle_on = on_now & ~on_q;
      wire clr = clear_faults | cycle_on;
      // R3 unmask criteria
      wire ready = ton_max_reached[g] & ton_delay_done[g] & ton_rise_done[g]
                   & above_uv_limit[g] & ~oc_present[g];
      // R4 R5 masked when inactive or ramping
      wire uv_det = uv_raw[g] & armed_q & on_now & ~toff_fall_active[g]
                    & ton_rise_done[g] & (st_q != OUVFR_ST_OFF) & (st_q != OUVFR_ST_WAIT);
      // R15 timeout disabled by zero
      wire ton_det = ton_timeout[g] & ~ton_max_zero[g] & on_now;
      wire retry_all = (retry == OUVFR_RETRY_ALWAYS);
      // next sticky values, set wins over clear
      wire uv_d = uv_det | (uv_q & ~clr);
      wire ton_d = ton_det | (ton_q & ~clr);

      assign cfg_all[g] = cfg_q;
      assign alert_req[g] = (uv_q & ~uv_alert_mask[g]) | (ton_q & ~ton_alert_mask[g]);

      // configuration register, bad code ignored
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          cfg_q <= OUVFR_CFG_RESET;
        end else if (cfg_wr && sel && !bad_wr) begin
          cfg_q <= cfg_wdata;
        end
      end

      // arming latches once the unmask criteria hold, until the channel goes inactive or ramps down
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          armed_q <= 1'b0;
          on_q <= 1'b0;
        end else begin
          on_q <= on_now;
          armed_q <= on_now & (armed_q | ready) & ~toff_fall_active[g];
        end
      end

      // R13 sticky status, set wins over clear
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          uv_q <= 1'b0;
          ton_q <= 1'b0;
          word_q <= 1'b0;
        end else begin
          // R1 uv status
          uv_q <= uv_d;
          // R14 timeout status
          ton_q <= ton_d;
          word_q <= uv_d | ton_d;
        end
      end

      assign status_vout_uv[g] = uv_q;
      assign status_vout_ton[g] = ton_q;
      assign status_word_vout[g] = word_q;
      assign status_byte_nota[g] = ton_q;

      // response state machine
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          st_q <= OUVFR_ST_RUN;
          cnt_q <= 16'h0000;
          output_enable[g] <= 1'b0;
        end else if (!on_now) begin
          st_q <= OUVFR_ST_RUN;
          cnt_q <= 16'h0000;
          output_enable[g] <= 1'b0;
        end else begin
          case (st_q)
            OUVFR_ST_RUN: begin
              output_enable[g] <= 1'b1;
              if (ton_det) begin
                st_q <= OUVFR_ST_OFF;
                output_enable[g] <= 1'b0;
              end else if (uv_det && mode == OUVFR_MODE_DEGLITCH) begin
                // R7 start delay
                st_q <= OUVFR_ST_DELAY;
                cnt_q <= 16'(dly);
              end else if (uv_det && mode == OUVFR_MODE_SHUTDOWN) begin
                // R8 immediate off
                st_q <= retry_all ? OUVFR_ST_WAIT : OUVFR_ST_OFF;
                cnt_q <= retry_interval_setting;
                output_enable[g] <= 1'b0;
              end
              // R6 mode 00 keeps running
            end
            OUVFR_ST_DELAY: begin
              if (!uv_det) begin
                st_q <= OUVFR_ST_RUN;
              end else if (cnt_q == 16'h0000) begin
                st_q <= retry_all ? OUVFR_ST_WAIT : OUVFR_ST_OFF;
                cnt_q <= retry_interval_setting;
                output_enable[g] <= 1'b0;
              end else if (tick) begin
                // R12 10 us units
                cnt_q <= cnt_q - 16'h0001;
              end
            end
            OUVFR_ST_OFF: begin
              // R10 stay off until cleared
              output_enable[g] <= 1'b0;
              if (clear_faults) begin
                st_q <= OUVFR_ST_RUN;
              end
            end
            default: begin
              // R11 retry after interval
              output_enable[g] <= 1'b0;
              if (cnt_q == 16'h0000) begin
                st_q <= OUVFR_ST_RUN;
              end else if (tick) begin
                cnt_q <= cnt_q - 16'h0001;
              end
            end
          endcase
        end
      end
    end
  endgenerate
endmodule : ouvfr_core

/* ouvfr_properties.sv */
`timescale 1ns/1ps
module ouvfr_properties
  import ouvfr_pkg::*;
#(
  parameter int NCH = OUVFR_NCH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // command side
  input wire logic [$clog2(NCH)-1:0] page,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic clear_faults,
  // channel side
  input wire logic [NCH-1:0] uv_alert_mask,
  input wire logic [NCH-1:0] channel_run_pin,
  input wire logic [NCH-1:0] operation_on,
  input wire logic [NCH-1:0] toff_fall_active,
  // status side
  input wire logic [NCH-1:0] output_enable,
  input wire logic [NCH-1:0] status_vout_uv,
  input wire logic [NCH-1:0] status_vout_ton,
  input wire logic [NCH-1:0] status_word_vout,
  input wire logic [NCH-1:0] status_byte_nota,
  input wire logic cml_fault,
  input wire logic alert_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // channel 0 commanded on, and its mode while page 0 is selected
  wire on0 = channel_run_pin[0] && operation_on[0];
  wire [1:0] md0 = (page == '0) ? cfg_rdata[7:6] : OUVFR_MODE_BAD;
  // status, alert and masking relations on channel 0, timeout on channel 1
  chk_uv_word_bit: assert property (status_vout_uv[0] |-> status_word_vout[0])
    else $error("uv bit without word bit");
  chk_ton_bits: assert property (status_vout_ton[1] |-> status_byte_nota[1] && status_word_vout[1])
    else $error("timeout bit without summary bits");
  chk_uv_alert: assert property ($rose(status_vout_uv[0]) && !uv_alert_mask[0] |=> !alert_n)
    else $error("alert not raised");
  chk_off_masked: assert property (!on0 |=> !$rose(status_vout_uv[0]))
    else $error("uv seen while off");
  chk_fall_masked: assert property (toff_fall_active[0] |=> !$rose(status_vout_uv[0]))
    else $error("uv seen during ramp down");
  chk_ignore_runs: assert property (output_enable[0] && on0 && md0 == OUVFR_MODE_IGNORE |=> output_enable[0])
    else $error("output dropped in ignore mode");
  chk_deglitch_runs: assert property ($rose(status_vout_uv[0]) && md0 == OUVFR_MODE_DEGLITCH
    && cfg_rdata[2:0] != 3'h0 |-> output_enable[0])
    else $error("output dropped before delay");
  chk_shut_now: assert property ($rose(status_vout_uv[0]) && md0 == OUVFR_MODE_SHUTDOWN |-> !output_enable[0])
    else $error("output not shut at once");
  chk_bad_mode: assert property (cfg_wr && cfg_wdata[7:6] == OUVFR_MODE_BAD |=> cml_fault)
    else $error("bad mode without cml fault");
  chk_uv_sticky: assert property (status_vout_uv[0] && on0 && $past(on0) && !clear_faults
    |=> status_vout_uv[0])
    else $error("uv bit lost");
  // main scenarios reached
  cov_shut: cover property ($fell(output_enable[0]));
  cov_cml: cover property ($rose(cml_fault));
  cov_ton: cover property ($rose(status_vout_ton[1]));
  cov_retry: cover property ($rose(output_enable[0]) && status_vout_uv[0]);
endmodule : ouvfr_properties

/* ouvfr_host_model.sv */
`timescale 1ns/1ps
// host side: paged config writes and clear pulses from falling edges
module ouvfr_host_model (
  // clock
  input wire logic sys_clk,
  // command outputs
  output logic page = 1'b0,
  output logic cfg_wr = 1'b0,
  output logic [7:0] cfg_wdata = 8'h00,
  output logic clear_faults = 1'b0
);
  // one-cycle write; data inverted once released
  task automatic wr(input logic ch, input logic [7:0] d);
    @(negedge sys_clk);
    page = ch;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge sys_clk);
    cfg_wr = 1'b0;
    cfg_wdata = ~d;
  endtask : wr
  // one-cycle clear pulse
  task automatic clr();
    @(negedge sys_clk);
    clear_faults = 1'b1;
    @(negedge sys_clk);
    clear_faults = 1'b0;
  endtask : clr
endmodule : ouvfr_host_model

/* tb.sv */
`timescale 1ns/1ps
module tb
  import ouvfr_pkg::*;
;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic page, cfg_wr, clear_faults, cml_fault, alert_n;
  logic [7:0] cfg_wdata, cfg_rdata;
  logic [1:0] run, rdy, fall, oc, uv, tto, um, tmz, oe, s_uv, s_ton, s_word, s_nota;
  int mismatches = 0;
  int samples_checked = 0;
  // clock
  always #20 sys_clk = ~sys_clk;
  // host and device
  ouvfr_host_model host (.sys_clk(sys_clk), .page(page), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .clear_faults(clear_faults));
  ouvfr_core #(.NCH(2), .UNIT_CYC(2)) i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .page(page), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .clear_faults(clear_faults), .retry_interval_setting(16'h0002), .ton_max_zero(tmz),
    .uv_alert_mask(um), .ton_alert_mask(2'h0), .channel_run_pin(run), .operation_on(2'h3),
    .ton_max_reached(rdy), .ton_delay_done(rdy), .ton_rise_done(rdy), .toff_fall_active(fall),
    .above_uv_limit(rdy), .oc_present(oc), .uv_raw(uv), .ton_timeout(tto),
    .output_enable(oe), .status_vout_uv(s_uv), .status_vout_ton(s_ton),
    .status_word_vout(s_word), .status_byte_nota(s_nota), .cml_fault(cml_fault),
    .alert_n(alert_n));
  // compare and count
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  // channel 0 off then on with the rdy arming inputs set; oc is left as the caller drives it
  task automatic up0();
    @(negedge sys_clk);
    run[0] = 1'b0;
    rdy[0] = 1'b1;
    repeat (3) @(negedge sys_clk);
    run[0] = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask : up0
  // one-cycle undervoltage event on channel 0
  task automatic uvp();
    uv[0] = 1'b1;
    @(negedge sys_clk);
    uv[0] = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask : uvp
  task automatic t_shut();
    chk("cfg reset", cfg_rdata, OUVFR_CFG_RESET);
    host.wr(1'b0, 8'h80);
    up0();
    chk("on", oe[0], 1'b1);
    uvp();
    chk("uv bit", s_uv[0], 1'b1);
    chk("word bit", s_word[0], 1'b1);
    chk("alert", alert_n, 1'b0);
    repeat (10) @(negedge sys_clk);
    chk("stays off", oe[0], 1'b0);
    chk("sticky", s_uv[0], 1'b1);
    host.clr();
    chk("cleared", s_uv[0], 1'b0);
    host.wr(1'b0, 8'hC5);
    chk("cml", cml_fault, 1'b1);
    chk("cfg kept", cfg_rdata, 8'h80);
  endtask : t_shut
  task automatic t_ignore();
    host.clr();
    chk("cml cleared", cml_fault, 1'b0);
    host.wr(1'b0, 8'h00);
    up0();
    um[0] = 1'b1;
    uvp();
    chk("ign bit", s_uv[0], 1'b1);
    chk("ign on", oe[0], 1'b1);
    chk("masked", alert_n, 1'b1);
    um[0] = 1'b0;
  endtask : t_ignore
  task automatic t_deg();
    host.wr(1'b0, 8'h43);
    up0();
    uv[0] = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("deg on", oe[0], 1'b1);
    repeat (12) @(negedge sys_clk);
    chk("deg off", oe[0], 1'b0);
    uv[0] = 1'b0;
  endtask : t_deg
  task automatic t_mask();
    host.wr(1'b0, 8'h80);
    oc[0] = 1'b1;
    up0();
    uvp();
    chk("oc mask", s_uv[0], 1'b0);
    oc[0] = 1'b0;
    up0();
    fall[0] = 1'b1;
    uvp();
    chk("fall mask", s_uv[0], 1'b0);
    fall[0] = 1'b0;
    repeat (2) @(negedge sys_clk);
    run[0] = 1'b0;
    uvp();
    chk("off mask", s_uv[0], 1'b0);
  endtask : t_mask
  task automatic t_retry();
    host.wr(1'b0, 8'hB8);
    up0();
    uvp();
    chk("retry off", oe[0], 1'b0);
    repeat (10) @(negedge sys_clk);
    chk("retry on", oe[0], 1'b1);
    chk("retry sticky", s_uv[0], 1'b1);
  endtask : t_retry
  task automatic t_ton();
    run[1] = 1'b1;
    rdy[1] = 1'b1;
    tmz[1] = 1'b1;
    tto[1] = 1'b1;
    @(negedge sys_clk);
    tto[1] = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("ton zero", s_ton[1], 1'b0);
    tmz[1] = 1'b0;
    tto[1] = 1'b1;
    @(negedge sys_clk);
    tto[1] = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("ton bits", {s_ton[1], s_nota[1], s_word[1], alert_n}, 8'h0E);
  endtask : t_ton
  // main sequence
  initial begin
    {run, rdy, fall, oc, uv, tto, um, tmz} = '0;
    repeat (12) @(negedge sys_clk);
    sys_rst = 1'b0;
    t_shut();
    t_ignore();
    t_deg();
    t_mask();
    t_retry();
    t_ton();
    print_verdict();
  end
  // watchdog
  initial begin
    repeat (3000) @(posedge sys_clk);
    mismatches++;
    print_verdict();
  end
endmodule : tb
bind ouvfr_core ouvfr_properties #(.NCH(NCH)) i_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .page(page), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
  .clear_faults(clear_faults), .uv_alert_mask(uv_alert_mask), .channel_run_pin(channel_run_pin),
  .operation_on(operation_on), .toff_fall_active(toff_fall_active), .output_enable(output_enable),
  .status_vout_uv(status_vout_uv), .status_vout_ton(status_vout_ton),
  .status_word_vout(status_word_vout), .status_byte_nota(status_byte_nota),
  .cml_fault(cml_fault), .alert_n(alert_n));
